// ---- logic/comparator_change_irq.sv ----
// Purpose: Change flags, interrupt requests and wake-up for two comparators.
// Assumes: clock_i keeps running in idle and power-down for this block.
// Notes:   Registers sit on a byte port; read data appears one cycle later.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module comparator_change_irq
   import cmp_pkg::*;
(
   input  wire logic               clock_i,
   input  wire logic               reset_i,
   input  wire logic               ce_i,
   input  wire reg_req_t           req_i,
   input  wire logic [NUM_CMP-1:0] raw_cmp_i,
   input  wire logic               sleep_i,
   output logic [DATA_W-1:0]       rdata_o,
   output logic                    irq_o,
   output logic [NUM_CMP-1:0]      cmp_irq_o,
   output logic                    wake_o,
   output logic [NUM_CMP-1:0]      turn_on_o,
   output logic [NUM_CMP-1:0]      pos_sel_o,
   output logic [NUM_CMP-1:0]      neg_sel_o,
   output logic [NUM_CMP-1:0]      result_pin_o,
   output logic [NUM_CMP-1:0]      result_pin_oe_o
);

   ctrl_reg_t          ctrl_q [NUM_CMP];
   ctrl_reg_t          ctrl_d [NUM_CMP];
   logic [DATA_W-1:0]  interrupt_enable_reg_zero_q;
   logic [DATA_W-1:0]  interrupt_enable_reg_zero_d;
   logic [DATA_W-1:0]  interrupt_enable_reg_one_q;
   logic [DATA_W-1:0]  interrupt_enable_reg_one_d;
   logic [NUM_CMP-1:0] stat_q;
   logic [NUM_CMP-1:0] stat_d;
   logic [NUM_CMP-1:0] mask_q;
   logic [NUM_CMP-1:0] mask_d;
   logic [DATA_W-1:0]  rdata_q;
   logic [DATA_W-1:0]  rdata_d;
   logic               irq_q;
   logic               irq_d;
   logic [NUM_CMP-1:0] req_q;
   logic [NUM_CMP-1:0] req_d;
   logic               wake_q;
   logic               wake_d;
   logic [NUM_CMP-1:0] synced;
   logic [NUM_CMP-1:0] chg;
   logic [NUM_CMP-1:0] ctrl_wr;
   logic [NUM_CMP-1:0] cmp_en;
   logic               global_en;
   logic [ADDR_W-1:0]  ctrl_addr [NUM_CMP];

   assign ctrl_addr[0] = ADDR_CTRL_ONE;
   assign ctrl_addr[1] = ADDR_CTRL_TWO;
   assign cmp_en       = interrupt_enable_reg_one_q[CMP_EN_LSB +: NUM_CMP];
   assign global_en    = interrupt_enable_reg_zero_q[GLOBAL_EN_BIT];

   // One detector per comparator; sleep does not gate detection.
   for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
      change_detect u_det (
         .clock_i  (clock_i),
         .reset_i  (reset_i),
         .ce_i     (ce_i),
         .enable_i (ctrl_q[i].comparator_turn_on),
         .raw_i    (raw_cmp_i[i]),
         .synced_o (synced[i]),
         .change_o (chg[i])
      );

      assign ctrl_wr[i] = req_i.wr && (req_i.addr == ctrl_addr[i]);

      // Control register: software fields, live output, sticky flag.
      always_comb begin
         ctrl_d[i] = ctrl_q[i];
         if (ctrl_wr[i]) begin
            ctrl_d[i] = ctrl_reg_t'(req_i.wdata);
            ctrl_d[i].reserved = 2'h0;
         end
         // The output bit is a hardware mirror and ignores writes.
         ctrl_d[i].synced_comparator_output = synced[i];
         // A toggle sets the flag even in the cycle software clears it.
         if (chg[i]) begin
            ctrl_d[i].output_change_flag = 1'b1;
         end
      end

      // The pin follows the synced result; drive follows result_pin_output_enable alone.
      assign turn_on_o[i]       = ctrl_q[i].comparator_turn_on;
      assign pos_sel_o[i]       = ctrl_q[i].positive_input_select;
      assign neg_sel_o[i]       = ctrl_q[i].negative_input_select;
      assign result_pin_o[i]    = ctrl_q[i].synced_comparator_output;
      assign result_pin_oe_o[i] = ctrl_q[i].result_pin_output_enable;
   end

   // Control registers clear to zero and freeze with the clock enable.
   always_ff @(posedge clock_i) begin
      for (int i = 0; i < NUM_CMP; i++) begin
         if (reset_i) begin
            ctrl_q[i] <= ctrl_reg_t'(REG_RESET);
         end else if (ce_i) begin
            ctrl_q[i] <= ctrl_d[i];
         end
      end
   end

   // Enable, status and mask registers, plus the read-back mux.
   always_comb begin
      interrupt_enable_reg_zero_d  = interrupt_enable_reg_zero_q;
      interrupt_enable_reg_one_d  = interrupt_enable_reg_one_q;
      mask_d  = mask_q;
      stat_d  = stat_q;
      rdata_d = READ_ZERO;
      if (req_i.wr) begin
         unique case (req_i.addr)
            ADDR_IEN_ZERO: interrupt_enable_reg_zero_d = req_i.wdata;
            ADDR_IEN_ONE:  interrupt_enable_reg_one_d = req_i.wdata;
            ADDR_EVT_MASK: mask_d = req_i.wdata[NUM_CMP-1:0];
            default:       ;
         endcase
      end
      // Flag bits can be polled at any time without interrupts on.
      if (req_i.rd) begin
         unique case (req_i.addr)
            ADDR_CTRL_ONE: rdata_d = DATA_W'(ctrl_q[0]);
            ADDR_CTRL_TWO: rdata_d = DATA_W'(ctrl_q[1]);
            ADDR_IEN_ZERO: rdata_d = interrupt_enable_reg_zero_q;
            ADDR_IEN_ONE:  rdata_d = interrupt_enable_reg_one_q;
            ADDR_EVT_STAT: rdata_d = DATA_W'(stat_q);
            ADDR_EVT_MASK: rdata_d = DATA_W'(mask_q);
            default:       rdata_d = READ_ZERO;
         endcase
         // Reading the status clears it; new events below still win.
         if (req_i.addr == ADDR_EVT_STAT) begin
            stat_d = EVT_RESET;
         end
      end
      stat_d = stat_d | chg;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         interrupt_enable_reg_zero_q  <= REG_RESET;
         interrupt_enable_reg_one_q  <= REG_RESET;
         mask_q  <= EVT_RESET;
         stat_q  <= EVT_RESET;
         rdata_q <= READ_ZERO;
      end else if (ce_i) begin
         interrupt_enable_reg_zero_q  <= interrupt_enable_reg_zero_d;
         interrupt_enable_reg_one_q  <= interrupt_enable_reg_one_d;
         mask_q  <= mask_d;
         stat_q  <= stat_d;
         rdata_q <= rdata_d;
      end
   end

   // Request needs flag, own enable and global enable; it is not cleared
   // when taken, so the handler must drop the flag itself. A wake request
   // is the same condition seen while in a reduced power mode.
   always_comb begin
      for (int i = 0; i < NUM_CMP; i++) begin
         req_d[i] = ctrl_q[i].output_change_flag
                    & cmp_en[i] & global_en;
      end
      wake_d = sleep_i & (|req_d);
      irq_d  = |(stat_d & mask_d);
   end

   // Every output leaves from a flop so the request edge is clean.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         req_q  <= EVT_RESET;
         wake_q <= 1'b0;
         irq_q  <= 1'b0;
      end else if (ce_i) begin
         req_q  <= req_d;
         wake_q <= wake_d;
         irq_q  <= irq_d;
      end
   end

   assign rdata_o   = rdata_q;
   assign irq_o     = irq_q;
   assign cmp_irq_o = req_q;
   assign wake_o    = wake_q;

   // Checks on the comparator side; frozen cycles are not judged.
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i || !ce_i);

   for (genvar k = 0; k < NUM_CMP; k++) begin : g_chk
      a_flag_on_change: assert property (
         chg[k] |=> ctrl_q[k].output_change_flag)
         else $error("change flag missed a toggle");

      a_flag_holds_poll: assert property (
         ctrl_q[k].output_change_flag && !ctrl_wr[k]
         |=> ctrl_q[k].output_change_flag)
         else $error("change flag dropped without a write");

      a_req_needs_all: assert property (
         cmp_irq_o[k] |-> $past(ctrl_q[k].output_change_flag)
         && $past(cmp_en[k]) && $past(global_en))
         else $error("request without flag and enables");

      a_req_when_all: assert property (
         ctrl_q[k].output_change_flag && cmp_en[k] && global_en
         |=> cmp_irq_o[k])
         else $error("request missing with flag and enables");

      a_sleep_detects: assert property (
         sleep_i && chg[k] |=> ##1 !cmp_en[k] || !global_en
         || cmp_irq_o[k] || !ctrl_q[k].output_change_flag)
         else $error("change in sleep did not request");

      a_off_reads_zero: assert property (
         !ctrl_q[k].comparator_turn_on |=> ##1
         !ctrl_q[k].synced_comparator_output)
         else $error("disabled comparator output not zero");

      a_change_compare: assert property (
         synced[k] != $past(synced[k]) |-> chg[k])
         else $error("synced output changed without detect");

      // A flag rises only through a toggle or a software write.
      a_flag_set_only: assert property (
         !ctrl_q[k].output_change_flag && !chg[k] && !ctrl_wr[k]
         |=> !ctrl_q[k].output_change_flag)
         else $error("change flag set without cause");

      // Each toggle is also logged for the shared interrupt output.
      a_status_on_change: assert property (
         chg[k] |=> stat_q[k])
         else $error("status bit missed a toggle");

      // Status bits are sticky; only a read of the status drops them.
      a_status_sticky: assert property (
         stat_q[k] && !(req_i.rd && req_i.addr == ADDR_EVT_STAT)
         |=> stat_q[k])
         else $error("status bit dropped without a read");

      // Unused control bits never hold state, whatever software writes.
      a_reserved_zero: assert property (
         ctrl_q[k].reserved == '0)
         else $error("reserved control bits not zero");

      // Either enable missing keeps the request low on the next cycle.
      a_req_gated_off: assert property (
         !(cmp_en[k] && global_en) |=> !cmp_irq_o[k])
         else $error("request raised with an enable off");

      // Sleep must not gate detection, so a toggle still lands.
      a_sleep_sets_flag: assert property (
         sleep_i && chg[k] |=> ctrl_q[k].output_change_flag)
         else $error("change in sleep did not set flag");

      // The synced stage is forced low while the comparator is off.
      a_sync_gated: assert property (
         !ctrl_q[k].comparator_turn_on |=> !synced[k])
         else $error("synced output high while off");

      a_sync_follows: assert property (
         ctrl_q[k].comparator_turn_on |=> synced[k] == $past(raw_cmp_i[k]))
         else $error("synced output does not follow raw");
   end

   a_wake_cause: assert property (
      wake_o |-> $past(sleep_i) && (|cmp_irq_o))
      else $error("wake without sleep and request");

   a_wake_raise: assert property (
      sleep_i && (|req_d) |=> wake_o && (|cmp_irq_o))
      else $error("enabled request in sleep did not wake");

   a_ctrl_reset_zero: assert property (
      @(posedge clock_i) $past(reset_i) |->
      ctrl_q[0].comparator_turn_on == 1'b0
      && ctrl_q[1].output_change_flag == 1'b0
      && interrupt_enable_reg_zero_q == REG_RESET)
      else $error("registers not zero after reset");

   a_read_clears: assert property (
      req_i.rd && req_i.addr == ADDR_EVT_STAT && !(|chg)
      |=> stat_q == EVT_RESET)
      else $error("status read did not clear");

   a_irq_level: assert property (
      irq_o == |(stat_q & mask_q))
      else $error("interrupt level disagrees with status");

   // Read data stand only in the cycle after a read strobe.
   a_rdata_idle: assert property (
      !req_i.rd |=> rdata_o == READ_ZERO)
      else $error("read data present without a read");

   // Polling the control register returns the flag as it stood.
   a_rdata_ctrl: assert property (
      req_i.rd && req_i.addr == ADDR_CTRL_ONE
      |=> rdata_o == DATA_W'($past(ctrl_q[0])))
      else $error("control read does not match register");

   // With every event masked the level output stays low.
   a_mask_blocks: assert property (
      mask_q == EVT_RESET && !req_i.wr |=> !irq_o)
      else $error("interrupt raised with all events masked");

   // Wake-up is meaningful only while in a reduced power mode.
   a_no_wake_awake: assert property (
      !sleep_i |=> !wake_o)
      else $error("wake raised while awake");

endmodule

// ---- shared/cmp_pkg.sv ----
// Purpose: Shared constants and carriers for the comparator change block.
// Assumes: Byte-wide register port with one-cycle strobes.
// Notes:   Register layouts are packed structs so bit positions live here.
package cmp_pkg;

   localparam int NUM_CMP = 2;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 8;

   // Register addresses on the byte-wide port.
   localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE  = 8'hac;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO  = 8'had;
   localparam logic [ADDR_W-1:0] ADDR_IEN_ZERO  = 8'ha8;
   localparam logic [ADDR_W-1:0] ADDR_IEN_ONE   = 8'he8;
   localparam logic [ADDR_W-1:0] ADDR_EVT_STAT  = 8'hb0;
   localparam logic [ADDR_W-1:0] ADDR_EVT_MASK  = 8'hb1;

   // Bit positions inside the interrupt enable registers.
   localparam int GLOBAL_EN_BIT = 7;
   localparam int CMP_EN_LSB    = 1;

   // Reset values.
   localparam logic [DATA_W-1:0]  REG_RESET  = 8'h00;
   localparam logic [NUM_CMP-1:0] EVT_RESET  = 2'h0;
   localparam logic [DATA_W-1:0]  READ_ZERO  = 8'h00;

   // Comparator control register layout, bit 7 down to bit 0.
   typedef struct packed {
      logic [1:0] reserved;
      logic       comparator_turn_on;
      logic       positive_input_select;
      logic       negative_input_select;
      logic       result_pin_output_enable;
      logic       synced_comparator_output;
      logic       output_change_flag;
   } ctrl_reg_t;

   // One cycle of the register port.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

endpackage

// ---- logic/change_detect.sv ----
// Purpose: Registers one comparator output and flags each toggle.
// Assumes: The analog result is already synchronous to clock_i.
// Notes:   A disabled comparator reads as zero, like the analog core idle.
`timescale 1ns/1ps
module change_detect
   import cmp_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic reset_i,
   input  wire logic ce_i,
   input  wire logic enable_i,
   input  wire logic raw_i,
   output logic      synced_o,
   output logic      change_o
);

   logic sync_q;
   logic sync_d;
   logic prev_q;
   logic prev_d;

   // Output reads zero while off; one means positive above negative.
   always_comb begin
      sync_d = enable_i & raw_i;
      prev_d = sync_q;
   end

   // Both stages freeze together with the clock enable.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else if (ce_i) begin
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // Compare the synced output with its previous sample.
   assign synced_o = sync_q;
   assign change_o = sync_q ^ prev_q;

endmodule

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the comparator change and interrupt block.
// Assumes: Timing of the register port and comparator path as handed over.
// Notes:   Inputs move by non-blocking assignment at the rising edge and
//          outputs are sampled at the falling edge, where they have settled.
`timescale 1ns/1ps
module tb;
   import cmp_pkg::*;
   logic               clock_i   = 1'b0;
   logic               reset_i   = 1'b1;
   logic               ce_i      = 1'b1;
   reg_req_t           req_i     = '0;
   logic [NUM_CMP-1:0] raw_cmp_i = 2'h0;
   logic               sleep_i   = 1'b0;
   logic [DATA_W-1:0]  rdata_o;
   logic               irq_o;
   logic               wake_o;
   logic [NUM_CMP-1:0] cmp_irq_o;
   logic [NUM_CMP-1:0] turn_on_o;
   logic [NUM_CMP-1:0] pos_sel_o;
   logic [NUM_CMP-1:0] neg_sel_o;
   logic [NUM_CMP-1:0] result_pin_o;
   logic [NUM_CMP-1:0] result_pin_oe_o;
   int                 n_errors    = 0;
   int                 check_count = 0;

   // Free-running 100 MHz clock.
   always #5 clock_i = ~clock_i;

   comparator_change_irq comparator_change_irq_inst (
      .clock_i         (clock_i),
      .reset_i         (reset_i),
      .ce_i            (ce_i),
      .req_i           (req_i),
      .raw_cmp_i       (raw_cmp_i),
      .sleep_i         (sleep_i),
      .rdata_o         (rdata_o),
      .irq_o           (irq_o),
      .cmp_irq_o       (cmp_irq_o),
      .wake_o          (wake_o),
      .turn_on_o       (turn_on_o),
      .pos_sel_o       (pos_sel_o),
      .neg_sel_o       (neg_sel_o),
      .result_pin_o    (result_pin_o),
      .result_pin_oe_o (result_pin_oe_o)
   );

   // Narrow values are zero-extended by the caller to keep widths exact.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      @(negedge clock_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      req_i.addr  <= a;
      req_i.wdata <= d;
      req_i.wr    <= 1'b1;
      @(posedge clock_i);
      req_i.wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the read strobe.
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      req_i.addr <= a;
      req_i.rd   <= 1'b1;
      @(posedge clock_i);
      req_i.rd   <= 1'b0;
      @(negedge clock_i);
      chk(rdata_o, exp);
   endtask

   // Toggling happens one edge after the call; detection needs a few edges.
   task automatic raw(input logic [1:0] v);
      @(posedge clock_i);
      raw_cmp_i <= v;
      cyc(4);
   endtask

   task automatic test_reset;
      logic [7:0] addrs [7];
      addrs = '{8'hac, 8'had, 8'ha8, 8'he8, 8'hb0, 8'hb1, 8'h00};
      foreach (addrs[i]) rchk(addrs[i], 8'h00);
      wr(8'hac, 8'hff);
      rchk(8'hac, 8'h3d);
      chk(rdata_o, 8'h3d);
      cyc(0);
      chk(rdata_o, 8'h00);
      chk({turn_on_o, pos_sel_o, neg_sel_o, result_pin_oe_o}, 8'h55);
      @(posedge clock_i);
      ce_i <= 1'b0;
      wr(8'hac, 8'h00);
      ce_i <= 1'b1;
      rchk(8'hac, 8'h3d);
      wr(8'h00, 8'hff);
      wr(8'hac, 8'h00);
      rchk(8'hac, 8'h00);
      $display("test_reset done");
   endtask

   task automatic test_poll;
      wr(8'hac, 8'h20);
      raw(2'h1);
      rchk(8'hac, 8'h23);
      chk({6'h00, result_pin_o}, 8'h01);
      chk({6'h00, cmp_irq_o}, 8'h00);
      chk({7'h00, irq_o}, 8'h00);
      rchk(8'hb0, 8'h01);
      rchk(8'hb0, 8'h00);
      wr(8'hac, 8'h22);
      rchk(8'hac, 8'h22);
      raw(2'h0);
      rchk(8'hac, 8'h21);
      $display("test_poll done");
   endtask

   task automatic test_irq;
      wr(8'had, 8'h20);
      // Settle time after turn-on, then clear the flag before enabling.
      cyc(1000);
      wr(8'had, 8'h20);
      wr(8'he8, 8'h06);
      cyc(3);
      chk({6'h00, cmp_irq_o}, 8'h00);
      wr(8'ha8, 8'h80);
      cyc(2);
      chk({6'h00, cmp_irq_o}, 8'h01);
      cyc(20);
      chk({6'h00, cmp_irq_o}, 8'h01);
      wr(8'hac, 8'h20);
      cyc(2);
      chk({6'h00, cmp_irq_o}, 8'h00);
      wr(8'hb1, 8'h02);
      raw(2'h2);
      chk({7'h00, irq_o}, 8'h01);
      chk({6'h00, cmp_irq_o}, 8'h02);
      rchk(8'hb0, 8'h03);
      cyc(1);
      chk({7'h00, irq_o}, 8'h00);
      wr(8'hb1, 8'h00);
      raw(2'h0);
      chk({7'h00, irq_o}, 8'h00);
      rchk(8'had, 8'h21);
      wr(8'had, 8'h20);
      rchk(8'hb0, 8'h02);
      $display("test_irq done");
   endtask

   task automatic test_sleep;
      @(posedge clock_i);
      sleep_i <= 1'b1;
      raw(2'h1);
      chk({7'h00, wake_o}, 8'h01);
      chk({6'h00, cmp_irq_o}, 8'h01);
      rchk(8'hac, 8'h23);
      wr(8'hac, 8'h22);
      cyc(2);
      chk({7'h00, wake_o}, 8'h00);
      wr(8'he8, 8'h00);
      raw(2'h0);
      chk({7'h00, wake_o}, 8'h00);
      rchk(8'hac, 8'h21);
      wr(8'hac, 8'h24);
      cyc(1);
      chk({6'h00, result_pin_oe_o}, 8'h01);
      @(posedge clock_i);
      sleep_i <= 1'b0;
      $display("test_sleep done");
   endtask

   // A toggle landing with a clearing write or a status read must win.
   task automatic test_collide;
      @(posedge clock_i);
      raw_cmp_i <= 2'h1;
      wr(8'hac, 8'h20);
      rchk(8'hac, 8'h23);
      @(posedge clock_i);
      raw_cmp_i <= 2'h0;
      rchk(8'hb0, 8'h01);
      rchk(8'hb0, 8'h01);
      $display("test_collide done");
   endtask

   // Reset in mid-run returns every output and register to zero.
   task automatic test_reset_again;
      @(posedge clock_i);
      reset_i <= 1'b1;
      cyc(2);
      chk({turn_on_o, result_pin_o, cmp_irq_o, irq_o, wake_o}, 8'h00);
      @(posedge clock_i);
      reset_i <= 1'b0;
      rchk(8'hac, 8'h00);
      rchk(8'ha8, 8'h00);
      $display("test_reset_again done");
   endtask

   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Main sequence: five cycles of reset, then each scenario in turn.
   initial begin
      repeat (5) @(posedge clock_i);
      reset_i <= 1'b0;
      test_reset;
      test_poll;
      test_irq;
      test_sleep;
      test_collide;
      test_reset_again;
      report_and_stop;
   end

   // The tests need about 1200 cycles, so 100 us means a hang.
   initial begin
      #100000;
      n_errors++;
      report_and_stop;
   end
endmodule
